// >>> hdl/sapr_buf_if.sv
// Valid and ready carrier for result words between the sequencer, buffer and output register.
`timescale 1ns/1ps
interface sapr_buf_if;
	logic [15:0] fill_data;
	logic        fill_valid;
	logic        fill_ready;
	logic [15:0] drain_data;
	logic        drain_valid;
	logic        drain_ready;

	modport buffer (
		input  fill_data,
		input  fill_valid,
		output fill_ready,
		output drain_data,
		output drain_valid,
		input  drain_ready
	);

	modport user (
		output fill_data,
		output fill_valid,
		input  fill_ready,
		input  drain_data,
		input  drain_valid,
		output drain_ready
	);
endinterface

// >>> hdl/sapr_pkg.sv
// Shared constants and types of the converter control and parallel readout block.
package sapr_pkg;

	// ------------------------------------------------------------------
	// Widths and buffer depth
	// ------------------------------------------------------------------
	localparam int unsigned RESULT_W   = 16;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned BUF_DEPTH  = 2;
	localparam int unsigned BIT_IDX_W  = 4;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CORE_CLK_PERIOD_PS = 5000;
	localparam int unsigned START_LOW_MIN_NS   = 20;
	localparam int unsigned BUSY_RISE_MAX_NS   = 25;
	localparam int unsigned BUSY_FALL_MAX_NS   = 25;
	// Least time rounds up.
	localparam int unsigned START_LOW_CYC =
		(START_LOW_MIN_NS * 1000 + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;
	// Longest times round down.
	localparam int unsigned BUSY_RISE_MAX_CYC = (BUSY_RISE_MAX_NS * 1000) / CORE_CLK_PERIOD_PS;
	localparam int unsigned BUSY_FALL_MAX_CYC = (BUSY_FALL_MAX_NS * 1000) / CORE_CLK_PERIOD_PS;
	localparam logic [2:0]  START_CNT_LAST    = 3'(START_LOW_CYC - 1);

	// ------------------------------------------------------------------
	// Reset, first trial and bit index end values
	// ------------------------------------------------------------------
	localparam logic [RESULT_W-1:0]  RESULT_RST = 16'h0000;
	localparam logic [RESULT_W-1:0]  TRIAL_MSB  = 16'h8000;
	localparam logic [BIT_IDX_W-1:0] BIT_MSB    = 4'hf;
	localparam logic [BIT_IDX_W-1:0] BIT_LSB    = 4'h0;
	localparam logic [RESULT_W-1:0]  LINES_OFF  = 16'hffff;

	// ------------------------------------------------------------------
	// Sequencer states, Gray coded along idle, convert, deliver
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SAPR_IDLE    = 2'h0,
		SAPR_CONVERT = 2'h1,
		SAPR_DELIVER = 2'h3
	} sapr_state_e;

	typedef logic [RESULT_W-1:0] sapr_word_t;

endpackage

// >>> hdl/sapr_result_buf.sv
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sapr_result_buf
	import sapr_pkg::*;
#(
	parameter int unsigned DEPTH = BUF_DEPTH
) (
	input  wire logic  core_clk_i,
	input  wire logic  rst_n_i,
	sapr_buf_if.buffer bus
);
	import sapr_pkg::*;

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	sapr_word_t         mem [DEPTH];
	logic [PTR_W-1:0]   wr_ptr;
	logic [PTR_W-1:0]   rd_ptr;
	logic [CNT_W-1:0]   count;
	logic               push;
	logic               pop;

	assign bus.fill_ready  = (count != CNT_W'(DEPTH));
	assign bus.drain_valid = (count != '0);
	assign bus.drain_data  = mem[rd_ptr];
	assign push            = bus.fill_valid & bus.fill_ready;
	assign pop             = bus.drain_valid & bus.drain_ready;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESULT_RST;
			end
		end else if (push) begin
			mem[wr_ptr] <= bus.fill_data;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= CNT_W'(count + 1'b1);
		end else if (pop && !push) begin
			count <= CNT_W'(count - 1'b1);
		end
	end

endmodule // sapr_result_buf

// >>> hdl/sapr_top.sv
// Successive-approximation sequencer with busy flag and parallel result readout.
`timescale 1ns/1ps
module sapr_top (
	input  wire logic                      core_clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      conversion_clk_i,
	input  wire logic                      conversion_start_n_i,
	input  wire logic                      chip_select_n_i,
	input  wire logic                      read_n_i,
	input  wire logic                      half_select_i,
	input  wire logic                      comparator_i,
	output logic                           busy_o,
	output logic                           sample_hold_o,
	output logic [sapr_pkg::RESULT_W-1:0]  dac_code_o,
	output logic [sapr_pkg::RESULT_W-1:0]  parallel_data_lines_o,
	output logic [sapr_pkg::RESULT_W-1:0]  parallel_data_lines_oe_n_o
);
	import sapr_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	sapr_state_e            state;
	sapr_state_e            next_state;
	logic                   conv_clk_prev;
	logic                   conv_clk_rise;
	logic                   start_armed;
	logic [2:0]             start_low_cnt;
	logic                   start_accept;
	logic [BIT_IDX_W-1:0]   bit_idx;
	sapr_word_t             trial;
	sapr_word_t             result_reg;
	logic                   selected;
	logic                   reading;
	logic                   push_done;

	sapr_buf_if buf_bus ();

	// ------------------------------------------------------------------
	// Conversion clock edge detection
	// ------------------------------------------------------------------
	// The conversion clock is at most 10 MHz, so sampling it at the core rate
	// sees every edge; a rising edge is a one-cycle strobe.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_clk_prev <= 1'b0;
		end else begin
			conv_clk_prev <= conversion_clk_i;
		end
	end

	assign conv_clk_rise = conversion_clk_i & ~conv_clk_prev;

	// ------------------------------------------------------------------
	// Start detection
	// ------------------------------------------------------------------
	assign selected = ~chip_select_n_i;

	// The start input must have been seen high since the last conversion
	// began, so a start held low across a whole conversion does not retrigger.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_armed <= 1'b0;
		end else if (conversion_start_n_i) begin
			start_armed <= 1'b1;
		end else if (start_accept) begin
			start_armed <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_low_cnt <= 3'h0;
		end else if (conversion_start_n_i || !selected || !start_armed) begin
			start_low_cnt <= 3'h0;
		end else if (start_low_cnt != START_CNT_LAST) begin
			start_low_cnt <= 3'(start_low_cnt + 3'h1);
		end
	end

	// Four low samples cover the 20 ns minimum and still leave busy inside 25 ns.
	assign start_accept = (state == SAPR_IDLE) && start_armed && selected
		&& !conversion_start_n_i && (start_low_cnt == START_CNT_LAST);

	// ------------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------------
	assign push_done = (state == SAPR_DELIVER) && conv_clk_rise && buf_bus.fill_ready;

	always_comb begin
		next_state = state;
		case (state)
			SAPR_IDLE: begin
				if (start_accept) begin
					next_state = SAPR_CONVERT;
				end
			end
			SAPR_CONVERT: begin
				if (conv_clk_rise && (bit_idx == BIT_LSB)) begin
					next_state = SAPR_DELIVER;
				end
			end
			SAPR_DELIVER: begin
				// A full buffer stalls here with busy still high.
				if (push_done) begin
					next_state = SAPR_IDLE;
				end
			end
			default: begin
				next_state = SAPR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= SAPR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Busy and sample-and-hold
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else if (start_accept) begin
			busy_o <= 1'b1;
		end else if (push_done) begin
			busy_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_hold_o <= 1'b0;
		end else if (start_accept) begin
			sample_hold_o <= 1'b1;
		end else if (push_done) begin
			sample_hold_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Successive approximation
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_idx <= BIT_MSB;
		end else if (start_accept) begin
			bit_idx <= BIT_MSB;
		end else if ((state == SAPR_CONVERT) && conv_clk_rise && (bit_idx != BIT_LSB)) begin
			bit_idx <= BIT_IDX_W'(bit_idx - 1'b1);
		end
	end

	// Each rising conversion clock edge in convert keeps or drops the bit under trial
	// and places the next lower one, except when the bit under trial is the LSB.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trial <= RESULT_RST;
		end else if (start_accept) begin
			trial <= TRIAL_MSB;
		end else if ((state == SAPR_CONVERT) && conv_clk_rise) begin
			trial[bit_idx] <= comparator_i;
			if (bit_idx != BIT_LSB) begin
				trial[bit_idx - 1'b1] <= 1'b1;
			end
		end
	end

	assign dac_code_o = trial;

	// ------------------------------------------------------------------
	// Result buffer
	// ------------------------------------------------------------------
	assign buf_bus.fill_data   = trial;
	assign buf_bus.fill_valid  = (state == SAPR_DELIVER) && conv_clk_rise;
	assign reading             = selected & ~read_n_i;
	// The output register does not change under an active read, so a word
	// arriving then waits in the buffer instead of tearing the read.
	assign buf_bus.drain_ready = ~reading;

	sapr_result_buf #(
		.DEPTH (BUF_DEPTH)
	) u_result_buf (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.bus        (buf_bus.buffer)
	);

	// ------------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result_reg <= RESULT_RST;
		end else if (buf_bus.drain_valid && buf_bus.drain_ready) begin
			result_reg <= buf_bus.drain_data;
		end
	end

	// ------------------------------------------------------------------
	// Parallel lines
	// ------------------------------------------------------------------
	// Half select is followed every cycle, so a change during a read shows
	// one cycle later without the strobe being raised.
	for (genvar b = 0; b < RESULT_W; b++) begin : g_line
		if (b < BYTE_W) begin : g_low
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					parallel_data_lines_o[b]      <= 1'b0;
					parallel_data_lines_oe_n_o[b] <= LINES_OFF[b];
				end else begin
					parallel_data_lines_o[b]      <= half_select_i ? result_reg[b + BYTE_W]
						: result_reg[b];
					parallel_data_lines_oe_n_o[b] <= ~reading;
				end
			end
		end else begin : g_high
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					parallel_data_lines_o[b]      <= 1'b0;
					parallel_data_lines_oe_n_o[b] <= LINES_OFF[b];
				end else begin
					parallel_data_lines_o[b]      <= result_reg[b];
					// Upper lines are released in byte mode.
					parallel_data_lines_oe_n_o[b] <= ~reading | half_select_i;
				end
			end
		end
	end

endmodule // sapr_top

// >>> sim/sapr_analog_model.sv
// Analog side stand-in: free-running conversion clock and an ideal comparator.
`timescale 1ns/1ps
module sapr_analog_model (
	input  wire logic [sapr_pkg::RESULT_W-1:0] dac_code_i,
	input  wire logic [sapr_pkg::RESULT_W-1:0] target_i,
	output logic                               comparator_o,
	output logic                               conversion_clk_o
);
	import sapr_pkg::*;
	// Edges sit off the core clock grid, so a sample never races an edge.
	initial begin
		conversion_clk_o = 1'b0;
		#1.3;
		forever #50 conversion_clk_o = ~conversion_clk_o;
	end
	// Keep the trial bit while the trial code does not exceed the input.
	assign comparator_o = (dac_code_i <= target_i);
endmodule // sapr_analog_model

// >>> sim/sapr_top_asserts.sv
// Port-level assertions of the converter control and readout block.
`timescale 1ns/1ps
module sapr_top_asserts (
	input wire logic                         core_clk_i,
	input wire logic                         rst_n_i,
	input wire logic                         conversion_clk_i,
	input wire logic                         conversion_start_n_i,
	input wire logic                         chip_select_n_i,
	input wire logic                         read_n_i,
	input wire logic                         half_select_i,
	input wire logic                         busy_o,
	input wire logic                         sample_hold_o,
	input wire logic [sapr_pkg::RESULT_W-1:0] dac_code_o,
	input wire logic [sapr_pkg::RESULT_W-1:0] parallel_data_lines_o,
	input wire logic [sapr_pkg::RESULT_W-1:0] parallel_data_lines_oe_n_o
);
	import sapr_pkg::*;
	logic       clk_prev;
	logic [5:0] rises;
	wire        rd_on = !chip_select_n_i && !read_n_i;
	// Counts conversion clock rises seen while busy is high.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_prev <= 1'b0;
			rises    <= 6'h00;
		end else begin
			clk_prev <= conversion_clk_i;
			if (!busy_o) rises <= 6'h00;
			else if (conversion_clk_i && !clk_prev) rises <= rises + 6'h01;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	hold_tracks_busy_a: assert property (sample_hold_o == busy_o)
		else $error("sample hold differs from busy");
	busy_cause_a: assert property ($rose(busy_o) |->
		!$past(conversion_start_n_i) && !$past(conversion_start_n_i, 4) && !$past(chip_select_n_i))
		else $error("busy rose without a start");
	busy_rise_a: assert property ($fell(conversion_start_n_i) && !chip_select_n_i && !busy_o
		##1 (!conversion_start_n_i && !chip_select_n_i)[*3] |=> busy_o)
		else $error("busy late after start");
	first_trial_a: assert property ($rose(busy_o) |-> dac_code_o == TRIAL_MSB)
		else $error("first trial code wrong");
	busy_fall_a: assert property ($fell(busy_o) |-> $past(conversion_clk_i)
		&& !$past(conversion_clk_i, 2) && rises >= 6'd17)
		else $error("busy fell off a clock rise or early");
	lines_release_a: assert property ((chip_select_n_i || read_n_i) |=>
		parallel_data_lines_oe_n_o == LINES_OFF) else $error("lines not released");
	word_drive_a: assert property (rd_on && !half_select_i |=>
		parallel_data_lines_oe_n_o == 16'h0000) else $error("word lines not driven");
	byte_drive_a: assert property (rd_on && half_select_i |=>
		parallel_data_lines_oe_n_o == 16'hff00) else $error("byte lines wrong");
	byte_follow_a: assert property (rd_on && !half_select_i ##1 rd_on && half_select_i |=>
		parallel_data_lines_o[7:0] == $past(parallel_data_lines_o[15:8]))
		else $error("byte not upper half");
	word_hold_a: assert property (rd_on && !half_select_i ##1 rd_on && !half_select_i |=>
		$stable(parallel_data_lines_o)) else $error("word changed in read");
	done_c: cover property ($fell(busy_o));
	start_c: cover property ($rose(busy_o));
	byte_c: cover property (rd_on && !half_select_i ##1 rd_on && half_select_i);
endmodule // sapr_top_asserts
bind sapr_top sapr_top_asserts u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.conversion_clk_i(conversion_clk_i), .conversion_start_n_i(conversion_start_n_i),
	.chip_select_n_i(chip_select_n_i), .read_n_i(read_n_i), .half_select_i(half_select_i),
	.busy_o(busy_o), .sample_hold_o(sample_hold_o), .dac_code_o(dac_code_o),
	.parallel_data_lines_o(parallel_data_lines_o),
	.parallel_data_lines_oe_n_o(parallel_data_lines_oe_n_o));

// >>> sim/tb.sv
// Self-checking bench of the converter control and readout block.
`timescale 1ns/1ps
module tb;
	import sapr_pkg::*;
	logic       core_clk_i, rst_n_i, conv_clk, start_n, cs_n, rd_n, half, cmp, busy, hold;
	sapr_word_t dac, data, oe_n, target;
	int         errors, check_count;
	sapr_top DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .conversion_clk_i(conv_clk),
		.conversion_start_n_i(start_n), .chip_select_n_i(cs_n), .read_n_i(rd_n),
		.half_select_i(half), .comparator_i(cmp), .busy_o(busy), .sample_hold_o(hold),
		.dac_code_o(dac), .parallel_data_lines_o(data), .parallel_data_lines_oe_n_o(oe_n));
	sapr_analog_model u_analog (.dac_code_i(dac), .target_i(target), .comparator_o(cmp),
		.conversion_clk_o(conv_clk));
	// ----
	// Tasks
	// ----
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input sapr_word_t got, input sapr_word_t exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	// Chip select stays low after the pulse when a read is being held.
	task automatic pulse(input int n, input logic csn);
		@(posedge core_clk_i);
		start_n <= 1'b0;
		cs_n    <= csn;
		repeat (n) @(posedge core_clk_i);
		start_n <= 1'b1;
		cs_n    <= rd_n;
	endtask
	task automatic wait_busy(input logic lvl, input int bound);
		int k;
		for (k = 0; k < bound && busy !== lvl; k++) @(negedge core_clk_i);
		chk(16'(busy), 16'(lvl));
	endtask
	task automatic convert(input sapr_word_t t, input bit wait_done);
		target <= t;
		pulse(6, 1'b0);
		tick(1);
		chk(16'(busy), 16'h0001);
		if (wait_done) wait_busy(1'b0, 500);
	endtask
	task automatic read_word(input sapr_word_t exp);
		@(posedge core_clk_i);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		tick(2);
		chk(oe_n, 16'h0000);
		chk(data, exp);
		@(posedge core_clk_i);
		half <= 1'b1;
		tick(2);
		chk(oe_n, 16'hff00);
		chk({8'h00, data[7:0]}, {8'h00, exp[15:8]});
		@(posedge core_clk_i);
		rd_n <= 1'b1;
		half <= 1'b0;
		tick(2);
		chk(oe_n, LINES_OFF);
		@(posedge core_clk_i);
		cs_n <= 1'b1;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_codes();
		sapr_word_t codes[4] = '{16'ha5c3, 16'hffff, 16'h0000, 16'h8001};
		foreach (codes[i]) begin
			convert(codes[i], 1'b1);
			read_word(codes[i]);
			read_word(codes[i]);
		end
	endtask
	task automatic t_refused();
		target <= 16'h1234;
		pulse(2, 1'b0);
		tick(8);
		chk(16'(busy), 16'h0000);
		pulse(6, 1'b1);
		tick(8);
		chk(16'(busy), 16'h0000);
		read_word(16'h8001);
	endtask
	// A held read stalls the output register, so two words fill the buffer.
	// Each one-cycle read release lets exactly one buffered word through.
	task automatic t_backlog();
		sapr_word_t held[2] = '{16'h0f0f, 16'hf0f0};
		@(posedge core_clk_i);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		convert(16'h0f0f, 1'b1);
		chk(data, 16'h8001);
		convert(16'hf0f0, 1'b1);
		convert(16'h3c3c, 1'b0);
		tick(700);
		chk(16'(busy), 16'h0001);
		foreach (held[i]) begin
			@(posedge core_clk_i);
			rd_n <= 1'b1;
			@(posedge core_clk_i);
			rd_n <= 1'b0;
			tick(2);
			chk(data, held[i]);
		end
		@(posedge core_clk_i);
		rd_n <= 1'b1;
		cs_n <= 1'b1;
		wait_busy(1'b0, 500);
		read_word(16'h3c3c);
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		rst_n_i = 1'b0;
		start_n = 1'b1;
		cs_n    = 1'b1;
		rd_n    = 1'b1;
		half    = 1'b0;
		target  = 16'h0000;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		tick(2);
		chk(oe_n, LINES_OFF);
		t_codes();
		t_refused();
		t_backlog();
		close_out();
	end
	initial begin
		#200us;
		errors++;
		close_out();
	end
endmodule // tb
